// file: pvs_pkg.sv
// Contract
// - frame sync stays high at least one whole line time per pulse.
// - at least two line times from frame sync edge to first active line sync.
// - at least one line time from line after last active line to frame sync.
// - total vertical blanking at least 6 + 8 x max(1, source/array lines) lines.
// - line sync stays high between 4 and 128 pixel clocks per pulse.
// - at least 4 pixel clocks from line sync edge to data valid rising.
// - at least 8 pixel clocks from data valid falling to next line sync.
// - eye select changes only when frame sync then stays put for 1.0 ms.
// - eye select stays put for 1.0 ms after any frame sync transition.
// - chip reset is held low at least 1.25 us.
// - master oscillator runs at 24 MHz within 200 ppm, no spread spectrum; the reference clock here has a 50 ns period, 20 MHz.
package pvs_pkg;

    localparam int PIX_W          = 24;
    localparam int HSW_MIN        = 4;
    localparam int HSW_MAX        = 128;
    localparam int HBP_MIN        = 4;
    localparam int HFP_MIN        = 8;
    localparam int VSW_MIN        = 1;
    localparam int VBP_MIN        = 2;
    localparam int VFP_MIN        = 1;
    localparam int VBLANK_BASE    = 6;
    localparam int VBLANK_SCALE   = 8;
    localparam int CLK_PERIOD_NS  = 50;
    localparam int RESET_LOW_NS   = 1250;
    localparam int EYE_GUARD_NS   = 1000000;
    localparam int PCLK_HALF      = 4;
    localparam int BUF_DEPTH      = 2;
    localparam int CNT_W          = 16;

    typedef enum logic [1:0] {
        ST_HOLD_RST,
        ST_IDLE,
        ST_FRAME
    } pvs_state_type;

    function automatic int pvs_max(input int a, input int b);
        return (a > b) ? a : b;
    endfunction : pvs_max

    function automatic int pvs_ceil_div(input int n, input int d);
        return (n + d - 1) / d;
    endfunction : pvs_ceil_div

    // least times round up to whole reference cycles, never below one
    localparam int RESET_LOW_CYC = pvs_max(1, pvs_ceil_div(RESET_LOW_NS, CLK_PERIOD_NS));
    localparam int EYE_GUARD_CYC = pvs_max(1, pvs_ceil_div(EYE_GUARD_NS, CLK_PERIOD_NS));

endpackage : pvs_pkg

// file: pvs_pclk_div.sv
module pvs_pclk_div #(
    parameter int HALF = pvs_pkg::PCLK_HALF
) (
    input  wire logic ref_clk,
    input  wire logic rst_n,
    output logic      pclk,
    output logic      fall_tick
);

    logic [7:0] cnt_r;
    logic       pclk_r;
    wire        last = (cnt_r == 8'(HALF - 1));

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r  <= 8'h00;
            pclk_r <= 1'b0;
        end else begin
            cnt_r  <= last ? 8'h00 : cnt_r + 8'h01;
            pclk_r <= last ? ~pclk_r : pclk_r;
        end
    end

    assign pclk = pclk_r;
    // pins change together with the falling edge, half a period before sampling
    assign fall_tick = last & pclk_r;

endmodule : pvs_pclk_div

// file: pvs_word_buf.sv
module pvs_word_buf #(
    parameter int W     = pvs_pkg::PIX_W,
    parameter int DEPTH = pvs_pkg::BUF_DEPTH
) (
    input  wire logic         ref_clk,
    input  wire logic         rst_n,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);

    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [W-1:0] mem_r [DEPTH];
    logic [AW-1:0] wr_r;
    logic [AW-1:0] rd_r;
    logic [AW:0]   cnt_r;
    logic          in_ready_r;

    wire push = in_valid & in_ready_r;
    wire pop  = out_ready & (cnt_r != '0);
    wire [AW:0] cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);

    function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
        return (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
    endfunction : bump

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_r       <= '0;
            rd_r       <= '0;
            cnt_r      <= '0;
            in_ready_r <= 1'b0;
        end else begin
            wr_r       <= push ? bump(wr_r) : wr_r;
            rd_r       <= pop ? bump(rd_r) : rd_r;
            cnt_r      <= cnt_nxt;
            in_ready_r <= (cnt_nxt != (AW+1)'(DEPTH));
        end
    end

    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem_r[wr_r] <= in_data;
        end
    end

    assign in_ready  = in_ready_r;
    assign out_valid = (cnt_r != '0);
    assign out_data  = mem_r[rd_r];

endmodule : pvs_word_buf

// file: pvs_video_source.sv
module pvs_video_source #(
    parameter int ACT_PIX       = 32,
    parameter int ACT_LINES     = 8,
    parameter int ARRAY_LINES   = 8,
    parameter int HSW           = 4,
    parameter int HBP           = 8,
    parameter int HFP           = 8,
    parameter int VSW           = 1,
    parameter int VBP           = 2,
    parameter int VFP           = 1,
    parameter int PCLK_HALF     = pvs_pkg::PCLK_HALF,
    parameter int EYE_GUARD_CYC = pvs_pkg::EYE_GUARD_CYC
) (
    input  wire logic                       ref_clk,
    input  wire logic                       reset_n,
    input  wire logic                       frame_enable,
    input  wire logic                       chip_reset_req,
    input  wire logic                       eye_req,
    input  wire logic                       pix_in_valid,
    output logic                            pix_in_ready,
    input  wire logic [pvs_pkg::PIX_W-1:0]  pix_in_data,
    output logic                            pixel_clock,
    output logic                            frame_sync,
    output logic                            line_sync,
    output logic                            pixel_valid_strobe,
    output logic [pvs_pkg::PIX_W-1:0]       pixel_bus,
    output logic                            stereo_eye_select,
    output logic                            chip_reset_n,
    output logic                            underrun
);

    localparam int CW = pvs_pkg::CNT_W;
    localparam int PER = 2 * PCLK_HALF;
    // porches and sync widths are raised to their least legal values; line sync width is also capped at HSW_MAX
    localparam int HSW_E = pvs_pkg::pvs_max(pvs_pkg::HSW_MIN,
                                            (HSW > pvs_pkg::HSW_MAX) ? pvs_pkg::HSW_MAX : HSW);
    localparam int HBP_E = pvs_pkg::pvs_max(HBP, pvs_pkg::HBP_MIN);
    localparam int HFP_E = pvs_pkg::pvs_max(HFP, pvs_pkg::HFP_MIN);
    localparam int VSW_E = pvs_pkg::pvs_max(VSW, pvs_pkg::VSW_MIN);
    localparam int VBP_E = pvs_pkg::pvs_max(VBP, pvs_pkg::VBP_MIN);
    localparam int VB_MIN = pvs_pkg::VBLANK_BASE + pvs_pkg::pvs_max(pvs_pkg::VBLANK_SCALE,
                            pvs_pkg::pvs_ceil_div(pvs_pkg::VBLANK_SCALE * ACT_LINES, ARRAY_LINES));
    localparam int VFP_E = pvs_pkg::pvs_max(pvs_pkg::pvs_max(VFP, pvs_pkg::VFP_MIN),
                                            VB_MIN - VBP_E);
    localparam int LINE_TOT  = HBP_E + ACT_PIX + HFP_E;
    localparam int FRAME_TOT = VBP_E + ACT_LINES + VFP_E;
    localparam int LINE_CYC  = LINE_TOT * PER;
    localparam int VS_HI_CYC = VSW_E * LINE_CYC;
    localparam int VS_LO_CYC = (FRAME_TOT - VSW_E) * LINE_CYC;

    localparam logic [CW-1:0] PIX_LAST  = CW'(LINE_TOT - 1);
    localparam logic [CW-1:0] LINE_LAST = CW'(FRAME_TOT - 1);
    localparam logic [CW-1:0] HS_END    = CW'(HSW_E);
    localparam logic [CW-1:0] DE_BEG    = CW'(HBP_E);
    localparam logic [CW-1:0] DE_END    = CW'(HBP_E + ACT_PIX);
    localparam logic [CW-1:0] VS_END    = CW'(VSW_E);
    localparam logic [CW-1:0] ACT_BEG   = CW'(VBP_E);
    localparam logic [CW-1:0] ACT_END   = CW'(VBP_E + ACT_LINES);
    localparam logic [31:0]   GUARD     = 32'(EYE_GUARD_CYC);
    localparam logic [31:0]   RST_CYC   = 32'(pvs_pkg::RESET_LOW_CYC);

    logic rst_meta_r;
    logic rst_n;

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta_r <= 1'b0;
            rst_n      <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n      <= rst_meta_r;
        end
    end

    // pop is wired into the buffer ahead of the position decode below
    logic tick;
    logic pop;
    logic buf_valid;
    logic [pvs_pkg::PIX_W-1:0] buf_data;

    pvs_pclk_div #(.HALF(PCLK_HALF)) u_div (
        .ref_clk   (ref_clk),
        .rst_n     (rst_n),
        .pclk      (pixel_clock),
        .fall_tick (tick)
    );

    pvs_word_buf #(.W(pvs_pkg::PIX_W), .DEPTH(pvs_pkg::BUF_DEPTH)) u_buf (
        .ref_clk   (ref_clk),
        .rst_n     (rst_n),
        .in_valid  (pix_in_valid),
        .in_ready  (pix_in_ready),
        .in_data   (pix_in_data),
        .out_valid (buf_valid),
        .out_ready (pop),
        .out_data  (buf_data)
    );

    pvs_pkg::pvs_state_type st_r;
    logic [CW-1:0] pix_r;
    logic [CW-1:0] line_r;
    logic [31:0]   rst_cnt_r;
    logic [31:0]   vs_since_r;
    logic [31:0]   vs_left_r;
    logic          fs_r;
    logic          ls_r;
    logic          de_r;
    logic [pvs_pkg::PIX_W-1:0] bus_r;
    logic          eye_r;
    logic          crst_r;
    logic          urun_r;

    // decoding of the current position within line and frame
    wire in_frame  = (st_r == pvs_pkg::ST_FRAME);
    wire pix_wrap  = (pix_r == PIX_LAST);
    wire line_wrap = pix_wrap & (line_r == LINE_LAST);
    wire hs_on     = in_frame & (pix_r < HS_END);
    wire vs_on     = in_frame & (line_r < VS_END);
    wire act_line  = (line_r >= ACT_BEG) & (line_r < ACT_END);
    wire de_on     = in_frame & act_line & (pix_r >= DE_BEG) & (pix_r < DE_END);
    assign pop     = tick & de_on;
    wire vs_flip   = tick & (vs_on != fs_r);
    // strictly above the guard: the eye flop lands one cycle after the decision
    wire eye_ok    = in_frame & (vs_since_r >= GUARD) & (vs_left_r > GUARD);
    wire eye_flip  = eye_ok & (eye_req != eye_r) & ~vs_flip;
    wire rst_done  = (rst_cnt_r >= RST_CYC);

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r   <= pvs_pkg::ST_HOLD_RST;
            pix_r  <= '0;
            line_r <= '0;
        end else begin
            unique case (st_r)
                pvs_pkg::ST_HOLD_RST: begin
                    if (rst_done && !chip_reset_req) begin
                        st_r <= pvs_pkg::ST_IDLE;
                    end
                end
                pvs_pkg::ST_IDLE: begin
                    if (chip_reset_req) begin
                        st_r <= pvs_pkg::ST_HOLD_RST;
                    end else if (tick && frame_enable) begin
                        st_r <= pvs_pkg::ST_FRAME;
                    end
                end
                pvs_pkg::ST_FRAME: begin
                    // frames always run to their end so the porches stay whole
                    if (tick) begin
                        pix_r  <= pix_wrap ? '0 : pix_r + CW'(1);
                        line_r <= line_wrap ? '0 : (pix_wrap ? line_r + CW'(1) : line_r);
                        if (line_wrap && (!frame_enable || chip_reset_req)) begin
                            st_r <= pvs_pkg::ST_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // frame sync, line sync, data valid and bus registers change only at the falling clock edge; underrun updates every reference cycle
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            fs_r   <= 1'b0;
            ls_r   <= 1'b0;
            de_r   <= 1'b0;
            bus_r  <= '0;
            urun_r <= 1'b0;
        end else begin
            urun_r <= pop & ~buf_valid;
            if (tick) begin
                fs_r  <= vs_on;
                ls_r  <= hs_on;
                de_r  <= de_on;
                bus_r <= (pop & buf_valid) ? buf_data : '0;
            end
        end
    end

    // cycles since and until frame sync changes, for eye select timing
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            vs_since_r <= '0;
            vs_left_r  <= '0;
        end else begin
            vs_since_r <= vs_flip ? '0 : ((vs_since_r < GUARD) ? vs_since_r + 32'h1 : vs_since_r);
            vs_left_r  <= vs_flip ? 32'(vs_on ? VS_HI_CYC : VS_LO_CYC)
                                  : ((vs_left_r != '0) ? vs_left_r - 32'h1 : vs_left_r);
        end
    end

    // eye may lag its request by a frame; short frames never allow a change
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            eye_r <= 1'b0;
        end else if (eye_flip) begin
            eye_r <= eye_req;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_cnt_r <= '0;
            crst_r    <= 1'b0;
        end else begin
            rst_cnt_r <= (st_r != pvs_pkg::ST_HOLD_RST) ? '0
                         : (rst_done ? rst_cnt_r : rst_cnt_r + 32'h1);
            crst_r    <= (st_r != pvs_pkg::ST_HOLD_RST);
        end
    end

    assign frame_sync         = fs_r;
    assign line_sync          = ls_r;
    assign pixel_valid_strobe = de_r;
    assign pixel_bus          = bus_r;
    assign stereo_eye_select  = eye_r;
    assign chip_reset_n       = crst_r;
    assign underrun           = urun_r;

    // checking helpers, counted in reference cycles
    logic [31:0] hs_hi_c;
    logic [31:0] hs_since_c;
    logic [31:0] de_lo_c;
    logic [31:0] de_hi_c;
    logic [31:0] vs_hi_c;
    logic [31:0] vs_rise_c;
    logic [31:0] eye_since_c;
    logic [31:0] crst_lo_c;
    logic        first_de_c;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            hs_hi_c     <= '0;
            hs_since_c  <= '0;
            de_lo_c     <= 32'hFFFF_FFFF;
            de_hi_c     <= '0;
            vs_hi_c     <= '0;
            vs_rise_c   <= '0;
            eye_since_c <= 32'hFFFF_FFFF;
            crst_lo_c   <= '0;
            first_de_c  <= 1'b0;
        end else begin
            hs_hi_c     <= ls_r ? hs_hi_c + 32'h1 : '0;
            hs_since_c  <= (ls_r && !$past(ls_r)) ? 32'h1 : hs_since_c + 32'h1;
            de_lo_c     <= de_r ? '0 : ((de_lo_c != 32'hFFFF_FFFF) ? de_lo_c + 32'h1 : de_lo_c);
            de_hi_c     <= de_r ? de_hi_c + 32'h1 : '0;
            vs_hi_c     <= fs_r ? vs_hi_c + 32'h1 : '0;
            vs_rise_c   <= (fs_r && !$past(fs_r)) ? 32'h1 : vs_rise_c + 32'h1;
            eye_since_c <= (eye_r != $past(eye_r)) ? 32'h1
                : ((eye_since_c != 32'hFFFF_FFFF) ? eye_since_c + 32'h1 : eye_since_c);
            crst_lo_c   <= crst_r ? '0 : crst_lo_c + 32'h1;
            first_de_c  <= (fs_r && !$past(fs_r)) ? 1'b1 : (de_r ? 1'b0 : first_de_c);
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    a_line_sync_width: assert property ($fell(ls_r) |->
        hs_hi_c >= 32'(pvs_pkg::HSW_MIN * PER) && hs_hi_c <= 32'(pvs_pkg::HSW_MAX * PER))
        else $error("line sync width out of range");
    a_back_porch_h: assert property ($rose(de_r) |->
        hs_since_c >= 32'(pvs_pkg::HBP_MIN * PER))
        else $error("data valid too soon after line sync");
    a_front_porch_h: assert property ($rose(ls_r) |->
        de_lo_c >= 32'(pvs_pkg::HFP_MIN * PER))
        else $error("line sync too soon after data valid");
    a_frame_sync_width: assert property ($fell(fs_r) |->
        vs_hi_c >= 32'(pvs_pkg::VSW_MIN * LINE_CYC))
        else $error("frame sync pulse shorter than a line");
    a_back_porch_v: assert property ($rose(de_r) && first_de_c |->
        vs_rise_c >= 32'(pvs_pkg::VBP_MIN * LINE_CYC))
        else $error("first active line too soon after frame sync");
    a_front_porch_v: assert property ($rose(fs_r) && $past(in_frame) |->
        de_lo_c >= 32'(pvs_pkg::VFP_MIN * LINE_CYC))
        else $error("frame sync too soon after last active line");
    a_vblank_total: assert property ($rose(de_r) && first_de_c |->
        de_lo_c >= 32'(VB_MIN * LINE_CYC))
        else $error("vertical blanking too short");
    a_eye_setup: assert property ($changed(fs_r) |->
        eye_since_c >= GUARD)
        else $error("frame sync changed too soon after eye select");
    a_eye_hold: assert property ($changed(eye_r) |->
        $past(vs_since_r) >= GUARD && !$changed(fs_r))
        else $error("eye select changed too soon after frame sync");
    a_chip_reset_low: assert property ($rose(crst_r) |->
        crst_lo_c >= RST_CYC)
        else $error("chip reset pulse too short");
    a_pins_at_rise: assert property ($rose(pixel_clock) |->
        $stable(bus_r) && $stable(ls_r) && $stable(de_r) ##1 $stable(bus_r))
        else $error("pixel pins moved at the sampling edge");
    a_active_width: assert property ($fell(de_r) |->
        de_hi_c == 32'(ACT_PIX * PER))
        else $error("data valid width differs from active pixels");

    c_line_done: cover property ($fell(de_r));
    c_frame_start: cover property ($rose(fs_r));
    c_eye_change: cover property ($changed(eye_r));
    c_underrun: cover property (urun_r);
    c_chip_reset: cover property ($rose(crst_r));

endmodule : pvs_video_source

// file: pvs_device_model.sv
module pvs_device_model (
    input wire logic                      pixel_clock,
    input wire logic                      chip_reset_n,
    input wire logic                      frame_sync,
    input wire logic                      line_sync,
    input wire logic                      pixel_valid_strobe,
    input wire logic [pvs_pkg::PIX_W-1:0] pixel_bus
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [pvs_pkg::PIX_W-1:0] cap [0:1023];
    int   ncap     = 0;
    int   pc       = 0;
    int   ls_pc    = 0;
    int   dvf_pc   = -1;
    int   ln       = 0;
    int   last_act = 0;
    int   vbp_cur  = 0;
    int   vsw_cnt  = 0;
    int   hsw_min  = 9999;
    int   hsw_max  = 0;
    int   hbp_min  = 9999;
    int   hfp_min  = 9999;
    int   vsw_min  = 9999;
    int   vbp_min  = 9999;
    int   vfp_min  = 9999;
    int   tvb_min  = 9999;
    logic act_seen = 1'b0;
    logic ls_q     = 1'b0;
    logic fs_q     = 1'b0;
    logic dv_q     = 1'b0;

    function automatic int mn(input int a, input int b);
        return (a < b) ? a : b;
    endfunction : mn

    // a device held in reset samples nothing
    always @(posedge pixel_clock) begin
        if (chip_reset_n === 1'b1) begin
            pc++;
            if (line_sync && !ls_q) begin
                if (frame_sync && !fs_q) begin
                    if (ln > 0) begin
                        vfp_min = mn(vfp_min, ln - last_act);
                        tvb_min = mn(tvb_min, vbp_cur + ln - last_act);
                    end
                    ln = 0;
                    vsw_cnt = 1;
                    act_seen = 1'b0;
                end else begin
                    ln++;
                    if (frame_sync) vsw_cnt++;
                end
                if (dvf_pc >= 0) hfp_min = mn(hfp_min, pc - dvf_pc);
                ls_pc = pc;
            end
            if (!line_sync && ls_q) begin
                hsw_min = mn(hsw_min, pc - ls_pc);
                if (pc - ls_pc > hsw_max) hsw_max = pc - ls_pc;
            end
            if (!frame_sync && fs_q) vsw_min = mn(vsw_min, vsw_cnt);
            if (pixel_valid_strobe && !dv_q) begin
                hbp_min = mn(hbp_min, pc - ls_pc);
                if (!act_seen) begin
                    vbp_cur = ln;
                    vbp_min = mn(vbp_min, ln);
                    act_seen = 1'b1;
                end
            end
            if (pixel_valid_strobe) last_act = ln;
            if (!pixel_valid_strobe && dv_q) dvf_pc = pc;
            // blanking words never reach the capture list
            if (pixel_valid_strobe && ncap < 1024) begin
                cap[ncap] = pixel_bus;
                ncap++;
            end
            ls_q = line_sync;
            fs_q = frame_sync;
            dv_q = pixel_valid_strobe;
        end
    end
endmodule : pvs_device_model

// file: test_parallel_video_input_timing.sv
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin n_errors++; \
    $display("Error at %0t: got %0h expected %0h", $time, (got), (exp)); end end

module test_parallel_video_input_timing;
    timeunit 1ns;
    timeprecision 1ns;

    localparam int GUARD   = 200;
    localparam int NPIX    = 32 * 8;
    localparam int TVB_MIN = pvs_pkg::VBLANK_BASE + pvs_pkg::VBLANK_SCALE * 2;

    logic                      ref_clk = 1'b0;
    logic                      reset_n;
    logic                      frame_enable;
    logic                      chip_reset_req;
    logic                      eye_req;
    logic                      pix_in_valid;
    logic                      pix_in_ready;
    logic [pvs_pkg::PIX_W-1:0] pix_in_data;
    logic                      pixel_clock;
    logic                      frame_sync;
    logic                      line_sync;
    logic                      pixel_valid_strobe;
    logic [pvs_pkg::PIX_W-1:0] pixel_bus;
    logic                      stereo_eye_select;
    logic                      chip_reset_n;
    logic                      underrun;
    logic                      feed_en;
    logic                      eye_d = 1'b0;
    logic                      fs_d = 1'b0;
    int                        next_word = 0;
    int                        n_errors = 0;
    int                        n_checks = 0;
    int                        n_under = 0;
    int                        n_eye = 0;
    int                        fs_age = 100000;
    int                        eye_age = 100000;
    int                        min_fs_gap = 100000;
    int                        min_eye_gap = 100000;

    always #(pvs_pkg::CLK_PERIOD_NS / 2) ref_clk = ~ref_clk;

    // shortened eye guard and odd porch values that the source must round up
    pvs_video_source #(.ARRAY_LINES(4), .HSW(2), .HBP(3), .HFP(5),
        .EYE_GUARD_CYC(GUARD)) u_dut (
        .ref_clk(ref_clk), .reset_n(reset_n), .frame_enable(frame_enable),
        .chip_reset_req(chip_reset_req), .eye_req(eye_req), .pix_in_valid(pix_in_valid),
        .pix_in_ready(pix_in_ready), .pix_in_data(pix_in_data), .pixel_clock(pixel_clock),
        .frame_sync(frame_sync), .line_sync(line_sync),
        .pixel_valid_strobe(pixel_valid_strobe), .pixel_bus(pixel_bus),
        .stereo_eye_select(stereo_eye_select), .chip_reset_n(chip_reset_n),
        .underrun(underrun));

    pvs_device_model u_dev (
        .pixel_clock(pixel_clock), .chip_reset_n(chip_reset_n), .frame_sync(frame_sync),
        .line_sync(line_sync), .pixel_valid_strobe(pixel_valid_strobe),
        .pixel_bus(pixel_bus));

    // feeder: counting words, so the captured order can be checked against it
    always @(negedge ref_clk) begin
        pix_in_valid = feed_en;
        pix_in_data  = next_word[pvs_pkg::PIX_W-1:0];
    end
    always @(posedge ref_clk) if (pix_in_valid && pix_in_ready === 1'b1) next_word++;

    // eye select against frame sync, in reference cycles
    always @(posedge ref_clk) begin
        if (reset_n) begin
            if (stereo_eye_select !== eye_d) begin
                n_eye++;
                if (fs_age < min_fs_gap) min_fs_gap = fs_age;
                eye_age = 0;
            end else eye_age++;
            if (frame_sync !== fs_d) begin
                if (eye_age < min_eye_gap) min_eye_gap = eye_age;
                fs_age = 0;
            end else fs_age++;
            eye_d = stereo_eye_select;
            fs_d  = frame_sync;
            if (underrun === 1'b1) n_under++;
        end
    end

    task automatic final_report;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : final_report

    task automatic wait_caps(input int n);
        for (int i = 0; i < 30000 && u_dev.ncap < n; i++) @(negedge ref_clk);
        `CHK(u_dev.ncap, n)
    endtask : wait_caps

    task automatic low_span(output int low);
        low = 0;
        while (chip_reset_n !== 1'b1 && low < 100) begin
            low++;
            @(negedge ref_clk);
        end
    endtask : low_span

    task automatic t_chip_reset;
        int low;
        low_span(low);
        `CHK(low >= pvs_pkg::RESET_LOW_CYC && low <= pvs_pkg::RESET_LOW_CYC + 6, 1'b1)
        chip_reset_req = 1'b1;
        for (int i = 0; i < 10 && chip_reset_n !== 1'b0; i++) @(negedge ref_clk);
        `CHK(chip_reset_n, 1'b0)
        chip_reset_req = 1'b0;
        low_span(low);
        `CHK(low >= pvs_pkg::RESET_LOW_CYC && low <= pvs_pkg::RESET_LOW_CYC + 3, 1'b1)
        $display("test chip_reset done");
    endtask : t_chip_reset

    task automatic t_refuse;
        time t0;
        feed_en = 1'b1;
        repeat (10) @(negedge ref_clk);
        `CHK(pix_in_ready, 1'b0)
        `CHK(next_word, pvs_pkg::BUF_DEPTH)
        @(posedge pixel_clock);
        t0 = $time;
        @(posedge pixel_clock);
        `CHK($time - t0, 2 * pvs_pkg::PCLK_HALF * pvs_pkg::CLK_PERIOD_NS)
        @(negedge ref_clk);
        $display("test refuse done");
    endtask : t_refuse

    task automatic t_frames;
        eye_req = 1'b1;
        frame_enable = 1'b1;
        wait_caps(NPIX + 40);
        frame_enable = 1'b0;
        wait_caps(2 * NPIX);
        repeat (9000) @(negedge ref_clk);
        `CHK(u_dev.ncap, 2 * NPIX)
        for (int i = 0; i < 2 * NPIX; i++) `CHK(u_dev.cap[i], i[23:0])
        `CHK(n_under, 0)
        `CHK(u_dev.hsw_min, pvs_pkg::HSW_MIN)
        `CHK(u_dev.hsw_max <= pvs_pkg::HSW_MAX, 1'b1)
        `CHK(u_dev.hbp_min, pvs_pkg::HBP_MIN)
        `CHK(u_dev.hfp_min, pvs_pkg::HFP_MIN)
        `CHK(u_dev.vsw_min, pvs_pkg::VSW_MIN)
        `CHK(u_dev.vbp_min, pvs_pkg::VBP_MIN)
        `CHK(u_dev.vfp_min >= pvs_pkg::VFP_MIN, 1'b1)
        `CHK(u_dev.tvb_min, TVB_MIN)
        `CHK(stereo_eye_select, 1'b1)
        $display("test frames done");
    endtask : t_frames

    task automatic t_underrun;
        int base;
        feed_en = 1'b0;
        eye_req = 1'b0;
        base = u_dev.ncap;
        n_under = 0;
        repeat (4) @(negedge ref_clk);
        frame_enable = 1'b1;
        wait_caps(base + 2);
        frame_enable = 1'b0;
        wait_caps(base + NPIX);
        repeat (9000) @(negedge ref_clk);
        `CHK(u_dev.cap[base], base[23:0])
        `CHK(u_dev.cap[base + 1], base[23:0] + 24'h000001)
        for (int i = 2; i < NPIX; i++) `CHK(u_dev.cap[base + i], 24'h000000)
        `CHK(n_under, NPIX - 2)
        `CHK(u_dev.tvb_min, TVB_MIN)
        `CHK(n_eye, 2)
        `CHK(stereo_eye_select, 1'b0)
        `CHK(min_fs_gap >= GUARD, 1'b1)
        `CHK(min_eye_gap >= GUARD, 1'b1)
        $display("test underrun done");
    endtask : t_underrun

    initial begin
        #4000000;
        n_errors++;
        $display("Error at %0t: watchdog expired", $time);
        final_report;
    end

    initial begin
        reset_n = 1'b0;
        frame_enable = 1'b0;
        chip_reset_req = 1'b0;
        eye_req = 1'b0;
        feed_en = 1'b0;
        repeat (8) @(negedge ref_clk);
        reset_n = 1'b1;
        t_chip_reset;
        t_refuse;
        t_frames;
        t_underrun;
        final_report;
    end
endmodule : test_parallel_video_input_timing
